// ---- verilog/option_byte_defines.vh ----
// Constants for the option byte configuration decoder
`ifndef OPTION_BYTE_DEFINES_VH
`define OPTION_BYTE_DEFINES_VH
// ----------------------------------------
// Programming port addresses
// ----------------------------------------
`define OB_ADDR_LSB 4'h0
`define OB_ADDR_MSB 4'h1
`define OB_ADDR_STATUS 4'h2
// ----------------------------------------
// Option bit positions in the 16-bit word
// ----------------------------------------
`define OB_BIT_OSC_SAFEGUARD_EN 0
`define OB_BIT_WDHW 1
`define OB_BIT_NMIPU 3
`define OB_BIT_OSCRC 6
`define OB_BIT_PROTECT 7
`define OB_BIT_LVD 8
`define OB_BIT_STOPWD 9
// ----------------------------------------
// Status register field positions
// ----------------------------------------
`define OB_ST_PROG 0
`define OB_ST_LOCK_LSB 1
`define OB_ST_LOCK_MSB 2
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define OB_BLANK_BYTE 8'h00
`define OB_ZERO_WORD 16'h0000
`define OB_RD_ZERO 8'h00
`define OB_SPIKE_NS 100
`define OB_CLK_NS 20
`endif

// ---- verilog/pin_sync.v ----
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire sys_clk_in,
    input wire srst_in,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    // First stage, read only by the second stage
    reg [WIDTH-1:0] meta_q;

    // ----------------------------------------
    // Double flop
    // ----------------------------------------
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            meta_q <= INIT;
            sync_out <= INIT;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // pin_sync
`default_nettype wire

// ---- verilog/otp_byte_cell.v ----
// One write-once option byte cell
`timescale 1ns/1ps
`include "option_byte_defines.vh"
`default_nettype none
module otp_byte_cell (
    input wire sys_clk_in,
    input wire blank_in,
    input wire wr_in,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg locked_out
);
    // ----------------------------------------
    // Cell storage
    // ----------------------------------------
    // Not cleared by the system reset: the cell models fuses that
    // survive every reset; only blank_in models a fresh part
    always @(posedge sys_clk_in)
    begin
        if (blank_in)
        begin
            data_out <= `OB_BLANK_BYTE;
            locked_out <= 1'b0;
        end
        else if (wr_in && !locked_out)
        begin
            // First write burns the byte and locks it
            data_out <= data_in;
            locked_out <= 1'b1;
        end
    end
endmodule // otp_byte_cell
`default_nettype wire

// ---- verilog/option_byte_config_decoder.v ----
// Option byte store, decoder and pin-level configuration logic
`timescale 1ns/1ps
`include "option_byte_defines.vh"
`default_nettype none
module option_byte_config_decoder #(
    parameter PORT_PINS = 9,
    parameter MASK_CODED = 0,
    parameter [15:0] MASK_OPTIONS = 16'h0000
) (
    input wire sys_clk_in,
    input wire srst_in,
    input wire blank_in,
    input wire [3:0] addr_in,
    input wire [7:0] wr_data_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rd_data_out,
    input wire program_voltage_pin_in,
    input wire nmi_pin_in,
    input wire reset_pin_n_in,
    input wire lvd_trip_in,
    input wire main_osc_fail_in,
    input wire stop_req_in,
    input wire wake_in,
    input wire sw_wdg_en_in,
    input wire ext_mem_rd_req_in,
    input wire port_cfg_wr_in,
    input wire [PORT_PINS-1:0] port_pullup_in,
    output reg core_reset_out,
    output reg prog_mode_out,
    output reg nmi_event_out,
    output reg nmi_pullup_en_out,
    output reg stop_with_watchdog_ctl_out,
    output reg low_voltage_detect_en_out,
    output reg read_protect_out,
    output reg ext_mem_rd_grant_out,
    output reg osc_rc_sel_out,
    output reg watchdog_hw_activate_out,
    output reg watchdog_run_out,
    output reg osc_safeguard_en_out,
    output reg backup_low_freq_osc_sel_out,
    output reg stop_exec_out,
    output reg wait_exec_out,
    output reg wdg_freeze_out,
    output reg [PORT_PINS-1:0] input_with_pullup_out
);
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    // Longest spike width that the safeguard ignores, rounded up
    localparam SPIKE_CYC = (`OB_SPIKE_NS + `OB_CLK_NS - 1) / `OB_CLK_NS;
    localparam [3:0] SPIKE_MAX = SPIKE_CYC[3:0];

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Synchronised pins: nmi, reset_n, lvd, osc fail
    // Reset loads the idle levels, pin pulled up and reset released,
    // so no false edge or core reset follows release of reset
    wire [3:0] pins_s;
    pin_sync #(
        .WIDTH(4),
        .INIT(4'h3)
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .async_in({main_osc_fail_in, lvd_trip_in, reset_pin_n_in,
                   nmi_pin_in}),
        .sync_out(pins_s)
    );
    wire nmi_s = pins_s[0];
    wire rstn_s = pins_s[1];
    wire lvd_s = pins_s[2];
    wire oscf_s = pins_s[3];

    // ----------------------------------------
    // Programming voltage synchroniser
    // ----------------------------------------
    // Kept out of reset on purpose: the level is only sampled while
    // reset is held, so a reset synchroniser would always read ground
    reg vpp_meta_q;
    // Second stage, the only reader of the first
    reg vpp_sync_q;
    always @(posedge sys_clk_in)
    begin
        vpp_meta_q <= program_voltage_pin_in;
        vpp_sync_q <= vpp_meta_q;
    end

    // ----------------------------------------
    // Option byte cells
    // ----------------------------------------
    // Programming mode, caught while reset is asserted
    reg prog_q;
    // Write enables into the two cells
    wire acc_ok = prog_q && (MASK_CODED == 0);
    wire wr_lsb = wr_in && acc_ok && (addr_in == `OB_ADDR_LSB);
    wire wr_msb = wr_in && acc_ok && (addr_in == `OB_ADDR_MSB);
    wire [7:0] lsb_cell;
    wire [7:0] msb_cell;
    wire lock_lsb;
    wire lock_msb;

    otp_byte_cell u_lsb (
        .sys_clk_in(sys_clk_in),
        .blank_in(blank_in),
        .wr_in(wr_lsb),
        .data_in(wr_data_in),
        .data_out(lsb_cell),
        .locked_out(lock_lsb)
    );

    otp_byte_cell u_msb (
        .sys_clk_in(sys_clk_in),
        .blank_in(blank_in),
        .wr_in(wr_msb),
        .data_in(wr_data_in),
        .data_out(msb_cell),
        .locked_out(lock_msb)
    );

    // Effective option word; a mask part ignores the cells
    wire [15:0] opt_src = (MASK_CODED != 0) ? MASK_OPTIONS
                                              : {msb_cell, lsb_cell};

    // ----------------------------------------
    // Decoded configuration latch
    // ----------------------------------------
    // Held option word, only refreshed during reset
    reg [15:0] opt_q;
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            opt_q <= opt_src;
            prog_q <= vpp_sync_q;
        end
    end

    // ----------------------------------------
    // Programming port read side
    // ----------------------------------------
    // Read data next cycle; zero outside programming mode
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
            rd_data_out <= `OB_RD_ZERO;
        else if (rd_in && acc_ok)
        begin
            case (addr_in)
                `OB_ADDR_LSB: rd_data_out <= lsb_cell;
                `OB_ADDR_MSB: rd_data_out <= msb_cell;
                `OB_ADDR_STATUS:
                begin
                    rd_data_out <= `OB_RD_ZERO;
                    rd_data_out[`OB_ST_PROG] <= prog_q;
                    rd_data_out[`OB_ST_LOCK_LSB] <= lock_lsb;
                    rd_data_out[`OB_ST_LOCK_MSB] <= lock_msb;
                end
                default: rd_data_out <= `OB_RD_ZERO;
            endcase
        end
        else
            // Unmapped, out-of-mode and mask reads answer zero
            rd_data_out <= `OB_RD_ZERO;
    end

    // ----------------------------------------
    // Static option outputs
    // ----------------------------------------
    // Option outputs register the held word; prog_mode_out registers prog_q
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            prog_mode_out <= 1'b0;
            stop_with_watchdog_ctl_out <= 1'b0;
            low_voltage_detect_en_out <= 1'b0;
            read_protect_out <= 1'b0;
            osc_rc_sel_out <= 1'b0;
            nmi_pullup_en_out <= 1'b0;
            watchdog_hw_activate_out <= 1'b0;
            osc_safeguard_en_out <= 1'b0;
        end
        else
        begin
            prog_mode_out <= prog_q;
            stop_with_watchdog_ctl_out <= opt_q[`OB_BIT_STOPWD];
            low_voltage_detect_en_out <= opt_q[`OB_BIT_LVD];
            read_protect_out <= opt_q[`OB_BIT_PROTECT];
            osc_rc_sel_out <= opt_q[`OB_BIT_OSCRC];
            nmi_pullup_en_out <= opt_q[`OB_BIT_NMIPU];
            watchdog_hw_activate_out <= opt_q[`OB_BIT_WDHW];
            osc_safeguard_en_out <= opt_q[`OB_BIT_OSC_SAFEGUARD_EN];
        end
    end

    // ----------------------------------------
    // Readout protection
    // ----------------------------------------
    // External reads only in programming mode and unprotected
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
            ext_mem_rd_grant_out <= 1'b0;
        else
            ext_mem_rd_grant_out <= ext_mem_rd_req_in && prog_q
                                    && !opt_q[`OB_BIT_PROTECT];
    end

    // ----------------------------------------
    // Reset combining
    // ----------------------------------------
    // Reset pin and enabled detector win over everything
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
            core_reset_out <= 1'b1;
        else
            core_reset_out <= !rstn_s
                              || (lvd_s && opt_q[`OB_BIT_LVD]);
    end

    // ----------------------------------------
    // Interrupt pin edge detect
    // ----------------------------------------
    // Previous synchronised level, reset high as if pulled up
    reg nmi_prev_q;
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            nmi_prev_q <= 1'b1;
            nmi_event_out <= 1'b0;
        end
        else
        begin
            nmi_prev_q <= nmi_s;
            // Pulse on high-to-low, masked while reset is active
            nmi_event_out <= nmi_prev_q && !nmi_s
                             && !core_reset_out;
        end
    end

    // ----------------------------------------
    // Oscillator safeguard
    // ----------------------------------------
    // Failure must persist past the spike window before switching
    // Trade-off: a real failure runs a few cycles on the bad clock
    // before the switch, in exchange for immunity to line spikes
    reg [3:0] spike_cnt_q;
    always @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            spike_cnt_q <= 4'h0;
            backup_low_freq_osc_sel_out <= 1'b0;
        end
        else if (!opt_q[`OB_BIT_OSC_SAFEGUARD_EN] || !oscf_s)
        begin
            // Safeguard off or clock healthy: count restarts
            spike_cnt_q <= 4'h0;
        end
        else if (spike_cnt_q < SPIKE_MAX)
            // Short glitches never reach the limit
            spike_cnt_q <= spike_cnt_q + 4'h1;
        else
            // Sticky until the next reset restarts the main clock
            backup_low_freq_osc_sel_out <= 1'b1;
    end

    // ----------------------------------------
    // Watchdog run and stop handling
    // ----------------------------------------
    // Watchdog runs if forced by option or enabled by software
    wire wdg_on = opt_q[`OB_BIT_WDHW] || sw_wdg_en_in;
    // Real stop allowed despite watchdog
    wire stop_ok = opt_q[`OB_BIT_STOPWD] && nmi_s;
    always @(posedge sys_clk_in)
    begin
        if (srst_in || core_reset_out)
        begin
            watchdog_run_out <= 1'b0;
            stop_exec_out <= 1'b0;
            wait_exec_out <= 1'b0;
            wdg_freeze_out <= 1'b0;
        end
        else
        begin
            watchdog_run_out <= wdg_on && !wdg_freeze_out;
            stop_exec_out <= stop_req_in && (!wdg_on || stop_ok);
            wait_exec_out <= stop_req_in && wdg_on && !stop_ok;
            if (stop_req_in && wdg_on && stop_ok)
                // Entering stop wins over a wake in the same cycle
                wdg_freeze_out <= 1'b1;
            else if (wake_in)
                // Wake ends the frozen state
                wdg_freeze_out <= 1'b0;
        end
    end

    // ----------------------------------------
    // Port pull-up state
    // ----------------------------------------
    // Every pin is a pulled-up input until software says otherwise
    genvar gi;
    generate
        for (gi = 0; gi < PORT_PINS; gi = gi + 1)
        begin : g_port
            always @(posedge sys_clk_in)
            begin
                if (srst_in)
                    input_with_pullup_out[gi] <= 1'b1;
                else if (port_cfg_wr_in)
                    input_with_pullup_out[gi] <= port_pullup_in[gi];
            end
        end
    endgenerate
endmodule // option_byte_config_decoder
`default_nettype wire

// ---- verification/prog_tool.sv ----
// Programming tool model driving the option byte port
`timescale 1ns/1ps
`default_nettype none
module prog_tool (
    input wire logic sys_clk_in,
    input wire logic [7:0] rd_data_in,
    output var logic [3:0] addr_out,
    output var logic [7:0] wr_data_out,
    output var logic wr_out,
    output var logic rd_out,
    output var logic vpp_out
);
    // Idle tool: no strobes, supply pin grounded
    initial
    begin
        addr_out = 4'h0;
        wr_data_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        vpp_out = 1'b0;
    end
    // Programming level only changed while reset is held
    task set_vpp(input logic v);
        vpp_out <= v;
    endtask
    // Reserved bits forced so no caller can break them
    task wr_byte(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        wr_data_out <= (a == 4'h1) ? ((d & 8'h03) | 8'h04) : ((d & 8'hCB) | 8'h14);
        wr_out <= 1'b1;
        @(posedge sys_clk_in);
        wr_out <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task rd_byte(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge sys_clk_in);
        rd_out <= 1'b0;
        @(negedge sys_clk_in);
        d = rd_data_in;
    endtask
endmodule // prog_tool
`default_nettype wire

// ---- verification/option_byte_config_decoder_assertions.sv ----
// Port-level checks for the option byte decoder
`timescale 1ns/1ps
`default_nettype none
module option_byte_config_decoder_assertions #(
    parameter PORT_PINS = 9,
    parameter MASK_CODED = 0
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic rd_in,
    input wire logic [7:0] rd_data_out,
    input wire logic prog_mode_out,
    input wire logic reset_pin_n_in,
    input wire logic lvd_trip_in,
    input wire logic nmi_pin_in,
    input wire logic stop_req_in,
    input wire logic port_cfg_wr_in,
    input wire logic core_reset_out,
    input wire logic nmi_event_out,
    input wire logic stop_with_watchdog_ctl_out,
    input wire logic low_voltage_detect_en_out,
    input wire logic read_protect_out,
    input wire logic ext_mem_rd_grant_out,
    input wire logic watchdog_run_out,
    input wire logic osc_safeguard_en_out,
    input wire logic backup_low_freq_osc_sel_out,
    input wire logic stop_exec_out,
    input wire logic wait_exec_out,
    input wire logic wdg_freeze_out,
    input wire logic [PORT_PINS-1:0] input_with_pullup_out
);
    // ----------------------------------------
    // Shared clocking and pin histories
    // ----------------------------------------
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    // Interrupt pin settled through the synchroniser
    sequence s_nmi_low;
        !nmi_pin_in [*4];
    endsequence
    sequence s_nmi_high;
        nmi_pin_in [*4];
    endsequence
    a_rd_quiet: assert property (
        !(rd_in && prog_mode_out && MASK_CODED == 0) |=> rd_data_out == 8'h00)
        else $error("read data without accepted read");
    a_pin_reset: assert property (!reset_pin_n_in [*4] |-> core_reset_out)
        else $error("reset pin low but core running");
    a_lvd_reset: assert property (
        (lvd_trip_in && low_voltage_detect_en_out) [*4] |-> core_reset_out)
        else $error("supply low but core running");
    a_nmi_edge: assert property (
        nmi_event_out |-> $past(nmi_pin_in, 4) && !$past(nmi_pin_in, 3))
        else $error("interrupt event without falling edge");
    a_stop_to_wait: assert property (
        s_nmi_low ##0 (stop_req_in && watchdog_run_out)
        |=> wait_exec_out && !stop_exec_out)
        else $error("stop not turned into wait");
    a_stop_frozen: assert property (
        s_nmi_high ##0 (stop_req_in && watchdog_run_out && stop_with_watchdog_ctl_out)
        |=> stop_exec_out && wdg_freeze_out)
        else $error("allowed stop not frozen");
    a_grant_blocked: assert property (read_protect_out |=> !ext_mem_rd_grant_out)
        else $error("protected memory read granted");
    a_osg_off: assert property (!osc_safeguard_en_out |-> !backup_low_freq_osc_sel_out)
        else $error("backup selected with safeguard off");
    a_backup_sticky: assert property (
        backup_low_freq_osc_sel_out |=> backup_low_freq_osc_sel_out)
        else $error("backup selection dropped");
    a_options_held: assert property (
        !$past(srst_in, 2) |-> $stable({stop_with_watchdog_ctl_out,
            low_voltage_detect_en_out, read_protect_out, osc_safeguard_en_out}))
        else $error("option outputs moved outside reset");
    a_pullup_held: assert property (!port_cfg_wr_in |=> $stable(input_with_pullup_out))
        else $error("port pull-ups changed without write");
endmodule // option_byte_config_decoder_assertions
bind option_byte_config_decoder option_byte_config_decoder_assertions #(
    .PORT_PINS(PORT_PINS),
    .MASK_CODED(MASK_CODED)
) u_option_byte_config_decoder_assertions (
    .sys_clk_in, .srst_in, .rd_in, .rd_data_out, .prog_mode_out, .reset_pin_n_in,
    .lvd_trip_in, .nmi_pin_in, .stop_req_in, .port_cfg_wr_in, .core_reset_out, .nmi_event_out,
    .stop_with_watchdog_ctl_out, .low_voltage_detect_en_out, .read_protect_out,
    .ext_mem_rd_grant_out, .watchdog_run_out, .osc_safeguard_en_out,
    .backup_low_freq_osc_sel_out, .stop_exec_out, .wait_exec_out, .wdg_freeze_out,
    .input_with_pullup_out
);
`default_nettype wire

// ---- verification/option_byte_config_decoder_tb.sv ----
// Self-checking bench for the option byte decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
    samples_checked = samples_checked + 1; \
    if ((got) !== (exp)) \
    begin \
        failures = failures + 1; \
        $display("Error %s expected %h seen %h", nm, exp, got); \
    end
module option_byte_config_decoder_tb;
    // ----------------------------------------
    // Stimulus, design outputs and counters
    // ----------------------------------------
    logic sys_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic blank_in = 1'b1;
    logic reset_pin_n_in = 1'b1;
    logic nmi_pin_in = 1'b1;
    logic lvd_trip_in = 1'b0;
    logic main_osc_fail_in = 1'b0;
    logic stop_req_in = 1'b0;
    logic wake_in = 1'b0;
    logic sw_wdg_en_in = 1'b0;
    logic ext_mem_rd_req_in = 1'b0;
    logic port_cfg_wr_in = 1'b0;
    logic [8:0] port_pullup_in = 9'h000;
    wire [3:0] p_addr;
    wire [7:0] p_wdata;
    wire [7:0] p_rdata;
    wire p_wr;
    wire p_rd;
    wire p_vpp;
    // Option outputs: stop-ctl, lvd, protect, rc, nmi pull, hw wdg, safeguard
    wire [6:0] opts;
    wire [8:0] pullups;
    wire core_rst;
    wire prog;
    wire nmi_ev;
    wire grant;
    wire wd_run;
    wire backup;
    wire stop_ex;
    wire wait_ex;
    wire freeze;
    int failures = 0;
    int samples_checked = 0;
    int nmi_cnt = 0;
    int stop_cnt = 0;
    int wait_cnt = 0;
    logic [7:0] rd_val;
    always #10 sys_clk_in = ~sys_clk_in;
    // One-cycle pulses counted at each rising edge
    always @(posedge sys_clk_in)
    begin
        if (nmi_ev === 1'b1) nmi_cnt = nmi_cnt + 1;
        if (stop_ex === 1'b1) stop_cnt = stop_cnt + 1;
        if (wait_ex === 1'b1) wait_cnt = wait_cnt + 1;
    end
    prog_tool u_prog_tool (.sys_clk_in(sys_clk_in), .rd_data_in(p_rdata), .addr_out(p_addr),
        .wr_data_out(p_wdata), .wr_out(p_wr), .rd_out(p_rd), .vpp_out(p_vpp));
    option_byte_config_decoder u_option_byte_config_decoder (.sys_clk_in(sys_clk_in),
        .srst_in(srst_in), .blank_in(blank_in), .addr_in(p_addr), .wr_data_in(p_wdata),
        .wr_in(p_wr), .rd_in(p_rd), .rd_data_out(p_rdata), .program_voltage_pin_in(p_vpp),
        .nmi_pin_in(nmi_pin_in), .reset_pin_n_in(reset_pin_n_in), .lvd_trip_in(lvd_trip_in),
        .main_osc_fail_in(main_osc_fail_in), .stop_req_in(stop_req_in), .wake_in(wake_in),
        .sw_wdg_en_in(sw_wdg_en_in), .ext_mem_rd_req_in(ext_mem_rd_req_in),
        .port_cfg_wr_in(port_cfg_wr_in), .port_pullup_in(port_pullup_in),
        .core_reset_out(core_rst), .prog_mode_out(prog), .nmi_event_out(nmi_ev),
        .nmi_pullup_en_out(opts[2]), .stop_with_watchdog_ctl_out(opts[6]),
        .low_voltage_detect_en_out(opts[5]), .read_protect_out(opts[4]),
        .ext_mem_rd_grant_out(grant), .osc_rc_sel_out(opts[3]),
        .watchdog_hw_activate_out(opts[1]), .watchdog_run_out(wd_run),
        .osc_safeguard_en_out(opts[0]), .backup_low_freq_osc_sel_out(backup),
        .stop_exec_out(stop_ex), .wait_exec_out(wait_ex), .wdg_freeze_out(freeze),
        .input_with_pullup_out(pullups));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    // Options are latched only while reset is held
    task do_reset(input logic v);
        srst_in <= 1'b1;
        u_prog_tool.set_vpp(v);
        tick(16);
        srst_in <= 1'b0;
        tick(3);
    endtask
    task rd_chk(input logic [3:0] a, input logic [7:0] exp);
        u_prog_tool.rd_byte(a, rd_val);
        `CHK("read data", exp, rd_val);
        @(posedge sys_clk_in);
    endtask
    task pulse_stop;
        stop_req_in <= 1'b1;
        tick(1);
        stop_req_in <= 1'b0;
        tick(2);
    endtask
    task wrap_up;
        if (failures == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard, well past the fewer than two hundred cycles used
    initial
    begin
        #60000;
        failures = failures + 1;
        wrap_up;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        tick(4);
        blank_in <= 1'b0;
        do_reset(1'b1);
        `CHK("options", 7'h00, opts);
        `CHK("prog mode", 1'b1, prog);
        `CHK("pull-ups", 9'h1FF, pullups);
        rd_chk(4'h0, 8'h00);
        rd_chk(4'h2, 8'h01);
        u_prog_tool.wr_byte(4'h0, 8'hFF);
        u_prog_tool.wr_byte(4'h1, 8'hFF);
        rd_chk(4'h0, 8'hDF);
        rd_chk(4'h1, 8'h07);
        u_prog_tool.wr_byte(4'h0, 8'h00);
        rd_chk(4'h0, 8'hDF);
        rd_chk(4'h2, 8'h07);
        rd_chk(4'h3, 8'h00);
        ext_mem_rd_req_in <= 1'b1;
        tick(2);
        `CHK("grant", 1'b1, grant);
        do_reset(1'b0);
        `CHK("options", 7'h7F, opts);
        `CHK("grant", 1'b0, grant);
        `CHK("prog mode", 1'b0, prog);
        `CHK("wdg run", 1'b1, wd_run);
        rd_chk(4'h0, 8'h00);
        port_pullup_in <= 9'h0A5;
        port_cfg_wr_in <= 1'b1;
        tick(1);
        port_cfg_wr_in <= 1'b0;
        tick(2);
        `CHK("pull-ups", 9'h0A5, pullups);
        pulse_stop;
        `CHK("stop count", 1, stop_cnt);
        `CHK("freeze", 1'b1, freeze);
        wake_in <= 1'b1;
        tick(1);
        wake_in <= 1'b0;
        tick(2);
        `CHK("freeze", 1'b0, freeze);
        nmi_pin_in <= 1'b0;
        tick(6);
        `CHK("nmi count", 1, nmi_cnt);
        pulse_stop;
        `CHK("wait count", 1, wait_cnt);
        nmi_pin_in <= 1'b1;
        tick(6);
        `CHK("nmi count", 1, nmi_cnt);
        main_osc_fail_in <= 1'b1;
        tick(3);
        main_osc_fail_in <= 1'b0;
        tick(6);
        `CHK("backup", 1'b0, backup);
        main_osc_fail_in <= 1'b1;
        tick(14);
        main_osc_fail_in <= 1'b0;
        tick(4);
        `CHK("backup", 1'b1, backup);
        lvd_trip_in <= 1'b1;
        tick(5);
        `CHK("core reset", 1'b1, core_rst);
        lvd_trip_in <= 1'b0;
        tick(5);
        `CHK("core reset", 1'b0, core_rst);
        reset_pin_n_in <= 1'b0;
        tick(5);
        `CHK("core reset", 1'b1, core_rst);
        reset_pin_n_in <= 1'b1;
        tick(5);
        do_reset(1'b1);
        `CHK("grant", 1'b0, grant);
        rd_chk(4'h1, 8'h07);
        wrap_up;
    end
endmodule // option_byte_config_decoder_tb
`default_nettype wire
